// ===== src/pss_sequencer.sv
// Positioning step sequencer: step store, chaining, trapezoid profile, registers
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pss_params.svh"

module pss_sequencer #(
  parameter int NUM_STEPS = `PSS_MAX_STEPS,
  parameter int CHAIN_LIMIT = `PSS_CHAIN_LIMIT,
  parameter int TICK_CYC = `PSS_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output pss_pkg::pss_phase_s phase,
  output pss_pkg::pss_drive_s drive
);

  localparam logic [7:0] NUM_W = 8'(NUM_STEPS);
  localparam logic [8:0] CHAIN_W = 9'(CHAIN_LIMIT);
  localparam logic [15:0] TICK_W = 16'(TICK_CYC - 1);

  pss_pkg::pss_step_s step_mem [0:NUM_STEPS-1];
  pss_pkg::pss_step_s cur_reg;
  pss_pkg::pss_state_e state_reg;
  logic [7:0] sel_reg;
  logic [7:0] cur_step_reg;
  logic [7:0] next_step_reg;
  logic [7:0] rep_def_reg;
  logic signed [31:0] pos_reg;
  logic [15:0] vel_reg;
  logic [31:0] brake_reg;
  logic [15:0] dwell_cnt_reg;
  logic [8:0] chain_cnt_reg;
  logic [7:0] err_reg;
  logic done_reg;
  logic [15:0] tick_cnt_reg;
  logic tick;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  pss_pkg::pss_drive_s drive_reg;

  logic start_cmd;
  logic stop_cmd;
  logic [7:0] start_num;
  logic dir_now;
  logic [31:0] remaining;
  logic [31:0] vel_ext;
  logic arrive;
  logic mode_bad;
  logic [7:0] rep_target;
  logic [7:0] chain_target;
  logic chain_over;
  logic seq_fin;
  logic ev_err;
  logic [31:0] status_word;

  // ****************************************
  // Command decode and motion terms
  // ****************************************
  assign start_cmd = reg_wr && reg_addr == `PSS_OFF_CTRL && reg_wdata[`PSS_CTRL_START_BIT];
  assign stop_cmd = reg_wr && reg_addr == `PSS_OFF_CTRL && reg_wdata[`PSS_CTRL_STOP_BIT];
  // Step zero means the step prepared by the previous completion
  assign start_num = reg_wdata[`PSS_CTRL_STEP_LSB +: 8] == 8'h00 ? next_step_reg :
                     reg_wdata[`PSS_CTRL_STEP_LSB +: 8];
  assign dir_now = cur_reg.goal > pos_reg;
  assign remaining = dir_now ? 32'(cur_reg.goal - pos_reg) : 32'(pos_reg - cur_reg.goal);
  assign vel_ext = {16'h0000, vel_reg};
  assign arrive = remaining <= vel_ext;
  // Speed control and zero speed cannot run here; a zero speed would never arrive
  assign mode_bad = cur_reg.ctl == pss_pkg::PSS_CTL_SPD ||
                    cur_reg.pat == pss_pkg::PSS_PAT_RSVD || cur_reg.speed == 16'h0000 ||
                    (cur_reg.ctl != pss_pkg::PSS_CTL_POS &&
                     cur_reg.pat == pss_pkg::PSS_PAT_CONT);
  assign rep_target = cur_reg.rep == 8'h00 ? rep_def_reg : cur_reg.rep;
  assign chain_target = cur_reg.mth == pss_pkg::PSS_MTH_REPEAT ? rep_target :
                        8'(cur_step_reg + 8'h01);
  assign chain_over = 9'(chain_cnt_reg + 9'h001) >= CHAIN_W;
  assign seq_fin = state_reg == pss_pkg::PSS_ST_NEXT;

  // ****************************************
  // Profile tick divider
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt_reg >= TICK_W) begin
      tick_cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ****************************************
  // Step store
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        step_mem[i] <= '0;
      end
    end else if (reg_wr && sel_reg != 8'h00 && sel_reg <= NUM_W) begin
      if (reg_addr == `PSS_OFF_STEP_MODE) begin
        step_mem[sel_reg - 8'h01].ctl <=
          pss_pkg::pss_ctl_e'(reg_wdata[`PSS_MODE_CTL_LSB +: 2]);
        step_mem[sel_reg - 8'h01].mth <= pss_pkg::pss_mth_e'(reg_wdata[`PSS_MODE_MTH_BIT]);
        step_mem[sel_reg - 8'h01].pat <=
          pss_pkg::pss_pat_e'(reg_wdata[`PSS_MODE_PAT_LSB +: 2]);
        step_mem[sel_reg - 8'h01].rep <= reg_wdata[`PSS_MODE_REP_LSB +: 8];
      end else if (reg_addr == `PSS_OFF_STEP_GOAL) begin
        step_mem[sel_reg - 8'h01].goal <= reg_wdata;
      end else if (reg_addr == `PSS_OFF_STEP_SPEED) begin
        step_mem[sel_reg - 8'h01].speed <= reg_wdata[15:0];
      end else if (reg_addr == `PSS_OFF_STEP_ACCEL) begin
        step_mem[sel_reg - 8'h01].accel <= reg_wdata[15:0];
      end else if (reg_addr == `PSS_OFF_STEP_DWELL) begin
        step_mem[sel_reg - 8'h01].dwell <= reg_wdata[15:0];
      end
    end
  end

  // ****************************************
  // Host settings
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= 8'h00;
      rep_def_reg <= `PSS_RST_REP_DEF;
      irq_mask_reg <= `PSS_RST_IRQ_MASK;
    end else if (reg_wr) begin
      if (reg_addr == `PSS_OFF_STEP_SEL) begin
        sel_reg <= reg_wdata[7:0];
      end else if (reg_addr == `PSS_OFF_REP_DEF) begin
        rep_def_reg <= reg_wdata[7:0];
      end else if (reg_addr == `PSS_OFF_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
    end
  end

  // ****************************************
  // Sequencer and trapezoid profile
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= pss_pkg::PSS_ST_IDLE;
      cur_reg <= '0;
      cur_step_reg <= 8'h00;
      pos_reg <= 32'sh0;
      vel_reg <= 16'h0000;
      brake_reg <= 32'h0;
      dwell_cnt_reg <= 16'h0000;
      chain_cnt_reg <= 9'h000;
      err_reg <= `PSS_ERR_NONE;
      done_reg <= 1'b0;
    end else if (stop_cmd) begin
      // Stop wins over everything, including a start in the same write
      state_reg <= pss_pkg::PSS_ST_IDLE;
      vel_reg <= 16'h0000;
    end else begin
      case (state_reg)
        pss_pkg::PSS_ST_IDLE: begin
          if (start_cmd) begin
            done_reg <= 1'b0;
            chain_cnt_reg <= 9'h000;
            if (start_num == 8'h00 || start_num > NUM_W) begin
              err_reg <= `PSS_ERR_RANGE;
            end else begin
              err_reg <= `PSS_ERR_NONE;
              cur_reg <= step_mem[start_num - 8'h01];
              cur_step_reg <= start_num;
              state_reg <= pss_pkg::PSS_ST_LOAD;
            end
          end
        end
        pss_pkg::PSS_ST_LOAD: begin
          vel_reg <= 16'h0000;
          brake_reg <= 32'h0;
          dwell_cnt_reg <= 16'h0000;
          if (mode_bad) begin
            err_reg <= `PSS_ERR_MODE;
            state_reg <= pss_pkg::PSS_ST_IDLE;
          end else begin
            state_reg <= pss_pkg::PSS_ST_ACCEL;
          end
        end
        pss_pkg::PSS_ST_ACCEL, pss_pkg::PSS_ST_CONST, pss_pkg::PSS_ST_DECEL: begin
          if (tick) begin
            if (arrive) begin
              pos_reg <= cur_reg.goal;
              vel_reg <= 16'h0000;
              // Continuous position steps pass through without dwell
              state_reg <= cur_reg.pat == pss_pkg::PSS_PAT_CONT ? pss_pkg::PSS_ST_NEXT :
                           pss_pkg::PSS_ST_DWELL;
            end else begin
              pos_reg <= dir_now ? pos_reg + $signed(vel_ext) : pos_reg - $signed(vel_ext);
              if (state_reg == pss_pkg::PSS_ST_DECEL) begin
                vel_reg <= vel_reg > 16'(cur_reg.accel + 16'h0001) ?
                           16'(vel_reg - cur_reg.accel) : 16'h0001;
              end else if (remaining - vel_ext <= brake_reg) begin
                state_reg <= pss_pkg::PSS_ST_DECEL;
              end else if (state_reg == pss_pkg::PSS_ST_ACCEL) begin
                if (vel_reg >= cur_reg.speed) begin
                  state_reg <= pss_pkg::PSS_ST_CONST;
                end else begin
                  // Braking distance mirrors the distance covered while speeding up
                  vel_reg <= 17'(vel_reg + cur_reg.accel) > 17'(cur_reg.speed) ?
                             cur_reg.speed : 16'(vel_reg + cur_reg.accel);
                  brake_reg <= brake_reg + vel_ext;
                end
              end
            end
          end
        end
        pss_pkg::PSS_ST_DWELL: begin
          if (tick) begin
            if (dwell_cnt_reg >= cur_reg.dwell) begin
              state_reg <= pss_pkg::PSS_ST_NEXT;
            end else begin
              dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
            end
          end
        end
        pss_pkg::PSS_ST_NEXT: begin
          if (cur_reg.pat == pss_pkg::PSS_PAT_END) begin
            done_reg <= 1'b1;
            state_reg <= pss_pkg::PSS_ST_IDLE;
          end else if (chain_over) begin
            err_reg <= `PSS_ERR_CHAIN;
            state_reg <= pss_pkg::PSS_ST_IDLE;
          end else if (chain_target == 8'h00 || chain_target > NUM_W) begin
            err_reg <= `PSS_ERR_RANGE;
            state_reg <= pss_pkg::PSS_ST_IDLE;
          end else begin
            // Keep and continuous steps chain on their own: repeat jumps to its repeat step, single goes to plus one
            chain_cnt_reg <= chain_cnt_reg + 9'h001;
            cur_reg <= step_mem[chain_target - 8'h01];
            cur_step_reg <= chain_target;
            state_reg <= pss_pkg::PSS_ST_LOAD;
          end
        end
        default: begin
          state_reg <= pss_pkg::PSS_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Step prepared for the next start
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      next_step_reg <= `PSS_RST_NEXT_STEP;
    end else if (seq_fin && cur_reg.pat == pss_pkg::PSS_PAT_END) begin
      if (cur_reg.mth == pss_pkg::PSS_MTH_REPEAT) begin
        next_step_reg <= rep_target;
      end else begin
        // Past the last step the sequence wraps to the first
        next_step_reg <= cur_step_reg >= NUM_W ? 8'h01 : 8'(cur_step_reg + 8'h01);
      end
    end
  end

  // ****************************************
  // Drive command and interrupts
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_reg <= '0;
    end else begin
      drive_reg.valid <= tick && !stop_cmd && (state_reg == pss_pkg::PSS_ST_ACCEL ||
                         state_reg == pss_pkg::PSS_ST_CONST ||
                         state_reg == pss_pkg::PSS_ST_DECEL);
      drive_reg.dir <= dir_now;
      drive_reg.pos <= arrive ? cur_reg.goal :
                       (dir_now ? pos_reg + $signed(vel_ext) : pos_reg - $signed(vel_ext));
    end
  end

  assign ev_err = (state_reg == pss_pkg::PSS_ST_IDLE && start_cmd && !stop_cmd &&
                   (start_num == 8'h00 || start_num > NUM_W)) ||
                  (state_reg == pss_pkg::PSS_ST_LOAD && mode_bad && !stop_cmd) ||
                  (seq_fin && !stop_cmd && cur_reg.pat != pss_pkg::PSS_PAT_END &&
                   (chain_over || chain_target == 8'h00 || chain_target > NUM_W));

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
                       ~((reg_wr && reg_addr == `PSS_OFF_IRQ_STAT) ? reg_wdata[2:0] : 3'h0)) |
                      {ev_err, seq_fin && !stop_cmd && cur_reg.pat == pss_pkg::PSS_PAT_END,
                       seq_fin && !stop_cmd};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // Register read port
  // ****************************************
  assign status_word = {8'h00, err_reg, cur_step_reg, 1'b0, err_reg != `PSS_ERR_NONE,
                        phase.done, phase.dwell, phase.decel, phase.constant,
                        phase.accel, phase.in_op};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == `PSS_OFF_STATUS) begin
        rdata_reg <= status_word;
      end else if (reg_addr == `PSS_OFF_IRQ_STAT) begin
        rdata_reg <= {29'h0, irq_stat_reg};
      end else if (reg_addr == `PSS_OFF_IRQ_MASK) begin
        rdata_reg <= {29'h0, irq_mask_reg};
      end else if (reg_addr == `PSS_OFF_STEP_SEL) begin
        rdata_reg <= {24'h0, sel_reg};
      end else if (reg_addr == `PSS_OFF_REP_DEF) begin
        rdata_reg <= {24'h0, rep_def_reg};
      end else if (reg_addr == `PSS_OFF_POSITION) begin
        rdata_reg <= pos_reg;
      end else if (reg_addr == `PSS_OFF_NEXT_STEP) begin
        rdata_reg <= {24'h0, next_step_reg};
      end else if (sel_reg != 8'h00 && sel_reg <= NUM_W) begin
        if (reg_addr == `PSS_OFF_STEP_MODE) begin
          rdata_reg <= {16'h0, step_mem[sel_reg - 8'h01].rep, 2'h0,
                        step_mem[sel_reg - 8'h01].pat, 1'b0,
                        step_mem[sel_reg - 8'h01].mth, step_mem[sel_reg - 8'h01].ctl};
        end else if (reg_addr == `PSS_OFF_STEP_GOAL) begin
          rdata_reg <= step_mem[sel_reg - 8'h01].goal;
        end else if (reg_addr == `PSS_OFF_STEP_SPEED) begin
          rdata_reg <= {16'h0, step_mem[sel_reg - 8'h01].speed};
        end else if (reg_addr == `PSS_OFF_STEP_ACCEL) begin
          rdata_reg <= {16'h0, step_mem[sel_reg - 8'h01].accel};
        end else if (reg_addr == `PSS_OFF_STEP_DWELL) begin
          rdata_reg <= {16'h0, step_mem[sel_reg - 8'h01].dwell};
        end else begin
          rdata_reg <= 32'h0;
        end
      end else begin
        rdata_reg <= 32'h0;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign drive = drive_reg;

  // ****************************************
  // Phase flags
  // ****************************************
  assign phase.in_op = state_reg != pss_pkg::PSS_ST_IDLE;
  assign phase.accel = state_reg == pss_pkg::PSS_ST_ACCEL;
  assign phase.constant = state_reg == pss_pkg::PSS_ST_CONST;
  assign phase.decel = state_reg == pss_pkg::PSS_ST_DECEL;
  assign phase.dwell = state_reg == pss_pkg::PSS_ST_DWELL;
  assign phase.done = done_reg;

  // ****************************************
  // Checks
  // ****************************************
  mode_reject_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == pss_pkg::PSS_ST_LOAD && mode_bad && !stop_cmd |=>
      state_reg == pss_pkg::PSS_ST_IDLE && err_reg == `PSS_ERR_MODE)
    else $error("invalid mode was not rejected");

  done_after_dwell_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(done_reg) |-> $past(state_reg, 2) == pss_pkg::PSS_ST_DWELL)
    else $error("completion without dwell");

  end_stops_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_fin && cur_reg.pat == pss_pkg::PSS_PAT_END && !stop_cmd |=>
      state_reg == pss_pkg::PSS_ST_IDLE && done_reg)
    else $error("end step did not stop");

  keep_next_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_fin && !stop_cmd && cur_reg.pat == pss_pkg::PSS_PAT_KEEP && !chain_over &&
    cur_reg.mth == pss_pkg::PSS_MTH_SINGLE && cur_step_reg < NUM_W |=>
      state_reg == pss_pkg::PSS_ST_LOAD && cur_step_reg == 8'($past(cur_step_reg) + 8'h01))
    else $error("keep step did not chain to next");

  repeat_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_fin && !stop_cmd && cur_reg.pat == pss_pkg::PSS_PAT_KEEP && !chain_over &&
    cur_reg.mth == pss_pkg::PSS_MTH_REPEAT && rep_target != 8'h00 && rep_target <= NUM_W |=>
      cur_step_reg == $past(rep_target))
    else $error("repeat keep did not jump to repeat step");

  repeat_end_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_fin && !stop_cmd && cur_reg.pat == pss_pkg::PSS_PAT_END &&
    cur_reg.mth == pss_pkg::PSS_MTH_REPEAT |=> next_step_reg == $past(rep_target))
    else $error("repeat step not prepared");

  chain_limit_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_fin && !stop_cmd && cur_reg.pat != pss_pkg::PSS_PAT_END && chain_over |=>
      state_reg == pss_pkg::PSS_ST_IDLE && err_reg == `PSS_ERR_CHAIN)
    else $error("chain limit not enforced");

  drive_dir_a: assert property (@(posedge core_clk) disable iff (rst)
    drive_reg.valid |-> drive_reg.dir == $past(cur_reg.goal > pos_reg))
    else $error("direction not from target");

  cruise_speed_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == pss_pkg::PSS_ST_CONST |-> vel_reg == cur_reg.speed && phase.constant)
    else $error("cruise below set speed");

  range_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == pss_pkg::PSS_ST_IDLE && start_cmd && !stop_cmd && start_num > NUM_W |=>
      state_reg == pss_pkg::PSS_ST_IDLE && err_reg == `PSS_ERR_RANGE)
    else $error("out of range step accepted");

endmodule : pss_sequencer

// ===== common/pss_params.svh
// Constants of the positioning step sequencer: offsets, fields, resets, timing
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PSS_OFF_CTRL 8'h00
`define PSS_OFF_STATUS 8'h04
`define PSS_OFF_IRQ_STAT 8'h08
`define PSS_OFF_IRQ_MASK 8'h0C
`define PSS_OFF_STEP_SEL 8'h10
`define PSS_OFF_STEP_MODE 8'h14
`define PSS_OFF_STEP_GOAL 8'h18
`define PSS_OFF_STEP_SPEED 8'h1C
`define PSS_OFF_STEP_ACCEL 8'h20
`define PSS_OFF_STEP_DWELL 8'h24
`define PSS_OFF_REP_DEF 8'h28
`define PSS_OFF_POSITION 8'h2C
`define PSS_OFF_NEXT_STEP 8'h30

// ****************************************
// Field positions
// ****************************************
`define PSS_CTRL_START_BIT 0
`define PSS_CTRL_STOP_BIT 1
`define PSS_CTRL_STEP_LSB 8
`define PSS_MODE_CTL_LSB 0
`define PSS_MODE_MTH_BIT 2
`define PSS_MODE_PAT_LSB 4
`define PSS_MODE_REP_LSB 8
`define PSS_STAT_CUR_LSB 8
`define PSS_STAT_ERR_LSB 16
`define PSS_IRQ_FIN_BIT 0
`define PSS_IRQ_DONE_BIT 1
`define PSS_IRQ_ERR_BIT 2

// ****************************************
// Reset values and error codes
// ****************************************
`define PSS_RST_REP_DEF 8'h01
`define PSS_RST_NEXT_STEP 8'h01
`define PSS_RST_IRQ_MASK 3'h0
`define PSS_ERR_NONE 8'h00
`define PSS_ERR_MODE 8'h01
`define PSS_ERR_CHAIN 8'h02
`define PSS_ERR_RANGE 8'h03

// ****************************************
// Timing and sizes
// ****************************************
`define PSS_CLK_NS 4
`define PSS_TICK_NS 1000
`define PSS_TICK_CYC (`PSS_TICK_NS / `PSS_CLK_NS)
`define PSS_MAX_STEPS 150
`define PSS_CHAIN_LIMIT 400

`endif

// ===== common/pss_pkg.sv
// Types of the positioning step sequencer
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_CTL_POS = 2'h0,
    PSS_CTL_LIN = 2'h1,
    PSS_CTL_CIR = 2'h2,
    PSS_CTL_SPD = 2'h3
  } pss_ctl_e;

  typedef enum logic {
    PSS_MTH_SINGLE = 1'b0,
    PSS_MTH_REPEAT = 1'b1
  } pss_mth_e;

  typedef enum logic [1:0] {
    PSS_PAT_END = 2'h0,
    PSS_PAT_KEEP = 2'h1,
    PSS_PAT_CONT = 2'h2,
    PSS_PAT_RSVD = 2'h3
  } pss_pat_e;

  typedef enum logic [6:0] {
    PSS_ST_IDLE = 7'h01,
    PSS_ST_LOAD = 7'h02,
    PSS_ST_ACCEL = 7'h04,
    PSS_ST_CONST = 7'h08,
    PSS_ST_DECEL = 7'h10,
    PSS_ST_DWELL = 7'h20,
    PSS_ST_NEXT = 7'h40
  } pss_state_e;

  typedef struct packed {
    pss_ctl_e ctl;
    pss_mth_e mth;
    pss_pat_e pat;
    logic [7:0] rep;
    logic signed [31:0] goal;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] dwell;
  } pss_step_s;

  typedef struct packed {
    logic in_op;
    logic accel;
    logic constant;
    logic decel;
    logic dwell;
    logic done;
  } pss_phase_s;

  typedef struct packed {
    logic valid;
    logic dir;
    logic signed [31:0] pos;
  } pss_drive_s;

endpackage : pss_pkg

// ===== verif/pss_drive_model.sv
// Motor drive model that follows the commanded positions of the sequencer
`timescale 1ns/1ps

module pss_drive_model #(
  parameter int STEP_MAX = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input pss_pkg::pss_drive_s drive,
  output logic signed [31:0] model_pos,
  output int model_errs
);
  // ****************************************
  // Follow the trajectory
  // ****************************************
  // A drive only counts pulses, so a wrong direction flag or an oversized
  // jump would move the axis somewhere the sequencer never meant
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      model_pos <= 32'sh0;
      model_errs <= 0;
    end else if (drive.valid) begin
      model_pos <= drive.pos;
      if ((drive.pos > model_pos && !drive.dir) || (drive.pos < model_pos && drive.dir)) begin
        model_errs <= model_errs + 1;
      end
      if (drive.pos - model_pos > STEP_MAX || model_pos - drive.pos > STEP_MAX) begin
        model_errs <= model_errs + 1;
      end
    end
  end
endmodule : pss_drive_model

// ===== verif/test_positioning_step_sequencer.sv
// Self-checking testbench of the positioning step sequencer
`timescale 1ns/1ps
`include "pss_params.svh"

module test_positioning_step_sequencer;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rnd = 32'h2EC70EFA, d;
  logic [31:0] g [1:4];
  logic [5:0] seen;
  logic signed [31:0] model_pos;
  pss_pkg::pss_phase_s phase;
  pss_pkg::pss_drive_s drive;
  int failures = 0, comparisons = 0, model_errs;

  pss_sequencer #(.TICK_CYC(2), .CHAIN_LIMIT(5)) u_dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .phase(phase), .drive(drive));
  pss_drive_model u_drive (.core_clk(core_clk), .rst(rst), .drive(drive),
    .model_pos(model_pos), .model_errs(model_errs));

  // ****************************************
  // Clock, phase history and helpers
  // ****************************************
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Any write clears the history, the last write before a run is its start
  always @(posedge core_clk) seen <= (reg_wr ? 6'h0 : seen) | 6'(phase);

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [31:0] md(input logic [1:0] c, input logic m,
                                     input logic [1:0] p, input logic [7:0] r);
    return {16'h0, r, 2'h0, p, 1'b0, m, c};
  endfunction : md
  task automatic end_sim;
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input string n, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    if (n != "") chk(n, d, e);
  endtask : rchk
  task automatic step(input logic [7:0] n, input logic [31:0] mode, input logic [31:0] goal);
    wr(`PSS_OFF_STEP_SEL, 32'(n));
    wr(`PSS_OFF_STEP_MODE, mode);
    wr(`PSS_OFF_STEP_GOAL, goal);
    wr(`PSS_OFF_STEP_SPEED, 32'h8);
    wr(`PSS_OFF_STEP_ACCEL, 32'h2);
    wr(`PSS_OFF_STEP_DWELL, 32'h2);
  endtask : step
  task automatic run(input logic [7:0] n);
    int i;
    wr(`PSS_OFF_CTRL, {16'h0, n, 8'h01});
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 20000 && phase.in_op !== 1'b0; i++) @(posedge core_clk);
    if (i == 20000) begin
      failures++;
      end_sim();
    end
  endtask : run

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 1; k <= 4; k++) begin
      rnd = lfsr(rnd);
      g[k] = 32'(rnd[7:0]) + 32'h60;
    end
    rchk(`PSS_OFF_IRQ_MASK, "irq_mask", 32'h0);
    rchk(`PSS_OFF_REP_DEF, "rep_def", 32'h1);
    rchk(`PSS_OFF_NEXT_STEP, "next_reset", 32'h1);
    rchk(8'hFC, "unmapped", 32'h0);
    step(8'h96, md(2'h1, 1'b0, 2'h0, 8'h0), g[1]);
    rchk(`PSS_OFF_STEP_GOAL, "goal_150", g[1]);
    wr(`PSS_OFF_STEP_SEL, 32'h97);
    wr(`PSS_OFF_STEP_GOAL, 32'h5);
    rchk(`PSS_OFF_STEP_GOAL, "goal_151", 32'h0);
    step(8'h01, md(2'h1, 1'b0, 2'h0, 8'h0), g[1]);
    run(8'h01);
    rchk(`PSS_OFF_POSITION, "pos_single", g[1]);
    chk("phases_seen", {26'h0, seen}, 32'h3F);
    rchk(`PSS_OFF_NEXT_STEP, "next_single", 32'h2);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(`PSS_OFF_IRQ_MASK, 32'h2);
    #1 chk("irq_done", {31'h0, irq}, 32'h1);
    wr(`PSS_OFF_IRQ_STAT, 32'h7);
    #1 chk("irq_clear", {31'h0, irq}, 32'h0);
    // Keep chain across a direction reversal, one start only
    step(8'h02, md(2'h1, 1'b0, 2'h1, 8'h0), -g[2]);
    step(8'h03, md(2'h2, 1'b0, 2'h0, 8'h0), g[3]);
    run(8'h02);
    rchk(`PSS_OFF_POSITION, "pos_chain", g[3]);
    chk("model_pos", model_pos, g[3]);
    rchk(`PSS_OFF_IRQ_STAT, "irq_stat", 32'h3);
    rchk(`PSS_OFF_NEXT_STEP, "next_chain", 32'h4);
    rchk(`PSS_OFF_STATUS, "", 32'h0);
    chk("done_flag", {31'h0, d[5]}, 32'h1);
    // Step 4 is still empty, so running on past the arc would raise a mode error
    chk("arc_end", {24'h0, d[23:16]}, 32'h0);
    wr(`PSS_OFF_REP_DEF, 32'h7);
    step(8'h04, md(2'h1, 1'b1, 2'h0, 8'h0), g[4]);
    run(8'h04);
    rchk(`PSS_OFF_NEXT_STEP, "next_repeat", 32'h7);
    // Repeat keep onto itself never reaches an end step
    step(8'h07, md(2'h2, 1'b1, 2'h1, 8'h7), g[4]);
    run(8'h00);
    rchk(`PSS_OFF_STATUS, "", 32'h0);
    chk("chain_error", {24'h0, d[23:16]}, 32'h2);
    chk("chain_flag", {31'h0, d[6]}, 32'h1);
    wr(`PSS_OFF_IRQ_MASK, 32'h4);
    #1 chk("irq_error", {31'h0, irq}, 32'h1);
    for (int c = 1; c <= 3; c++) begin
      step(8'h05, md(2'(c), 1'b0, 2'h2, 8'h0), g[1]);
      run(8'h05);
      rchk(`PSS_OFF_STATUS, "", 32'h0);
      chk("mode_error", {24'h0, d[23:16]}, 32'h1);
    end
    run(8'h97);
    rchk(`PSS_OFF_STATUS, "", 32'h0);
    chk("range_error", {24'h0, d[23:16]}, 32'h3);
    // A stop in mid-move ends the run at once and never reports completion
    wr(`PSS_OFF_CTRL, 32'h0101);
    repeat (4) @(posedge core_clk);
    wr(`PSS_OFF_CTRL, 32'h2);
    rchk(`PSS_OFF_STATUS, "", 32'h0);
    chk("stop_idle", {26'h0, d[5:0]}, 32'h0);
    chk("drive_model", 32'(model_errs), 32'h0);
    end_sim();
  end
endmodule : test_positioning_step_sequencer
